// *** shared/sec_pkg.sv ***
// Purpose: Shared constants and types for the serial EEPROM command frame block.
// Assumes: Core clock at 250 MHz; shift clock supplied by the host only during frames.
// Notes:   Frame bits after the start bit are opcode, address, then optional data.
package sec_pkg;

  // Core clock period.
  localparam real CLK_PERIOD_NS = 4.0;

  // Frame geometry.
  localparam int unsigned OPC_W       = 2;
  localparam int unsigned ADDR_W      = 10;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned MEM_WORDS   = 1024;
  localparam int unsigned BITS_W      = OPC_W + ADDR_W + DATA_W;
  localparam int unsigned CNT_W       = 5;
  localparam logic [4:0]  CNT_MAX     = 5'h1f;
  localparam logic [4:0]  LEN_SHORT   = 5'h0d;
  localparam logic [4:0]  LEN_LONG    = 5'h1d;

  // Field positions inside the shifted bits, per frame length.
  localparam int unsigned S_OPC_LSB   = ADDR_W;
  localparam int unsigned L_OPC_LSB   = ADDR_W + DATA_W;
  localparam int unsigned L_ADDR_LSB  = DATA_W;
  localparam int unsigned SUB_LSB     = ADDR_W - 2;

  // Opcodes and the sub-codes carried in the top address bits.
  localparam logic [1:0] OPC_EXT      = 2'h0;
  localparam logic [1:0] OPC_WRITE    = 2'h1;
  localparam logic [1:0] OPC_READ     = 2'h2;
  localparam logic [1:0] OPC_ERASE    = 2'h3;
  localparam logic [1:0] SUB_LOCK     = 2'h0;
  localparam logic [1:0] SUB_WR_ALL   = 2'h1;
  localparam logic [1:0] SUB_ER_ALL   = 2'h2;
  localparam logic [1:0] SUB_UNLOCK   = 2'h3;

  // Reset values.
  localparam logic [15:0] MEM_INIT    = 16'hffff;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic        UNLOCK_INIT = 1'b0;

  // Timing: least deselect time the host keeps, program cycle typical and longest.
  localparam real MIN_DESELECT_US   = 0.2;
  localparam int  MIN_DESELECT_CYC  = int'($ceil(MIN_DESELECT_US * 1000.0 / CLK_PERIOD_NS));
  localparam real PROG_TYP_MS       = 2.0;
  localparam real PROG_MAX_MS       = 4.0;
  localparam int  PROG_TYP_CYC      = int'($floor(PROG_TYP_MS * 1000000.0 / CLK_PERIOD_NS));
  localparam int  PROG_MAX_CYC      = int'($floor(PROG_MAX_MS * 1000000.0 / CLK_PERIOD_NS));
  localparam int unsigned TIMER_W   = 21;

  // One received frame as the link side hands it over.
  typedef struct packed {
    logic [CNT_W-1:0]  count;
    logic [BITS_W-1:0] bits;
  } sec_frame_s;

  // A program request latched at the end of a frame.
  typedef struct packed {
    logic              all;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sec_prog_s;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_PROG
  } sec_state_e;

endpackage

// *** src/sec_frame_rx.sv ***
// Purpose: Shift-clock side receiver that collects one command frame.
// Assumes: Serial input meets setup and hold around shift clock rising edges.
// Notes:   The started flag is cleared asynchronously by select falling.
`timescale 1ns/10ps
module sec_frame_rx
  import sec_pkg::*;
(
  input  wire logic       i_shift_clock_pin,
  input  wire logic       i_reset_n,
  input  wire logic       i_select_pin,
  input  wire logic       i_serial_in_pin,
  output sec_frame_s      o_frame,
  output logic            o_start_toggle
);

  // Standby clears the started flag with no clock edge, since the shift clock stops.
  wire clear_n = i_reset_n & i_select_pin;  // [R5] [R3]

  logic started;
  // Select gates the start bit too, so a stray high input in standby cannot toggle a start.
  wire  take_start = i_select_pin & ~started & i_serial_in_pin;  // [R5]
  wire  at_max     = (o_frame.count == CNT_MAX);

  // Wait for the first high bit; low bits before it are padding.
  always_ff @(posedge i_shift_clock_pin or negedge clear_n) begin
    if (!clear_n) begin
      started <= 1'b0;
    end else if (take_start) begin
      started <= 1'b1;  // [R8]
    end
  end

  // Bits and count survive select low so the core can read them after the frame.
  always_ff @(posedge i_shift_clock_pin or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_frame        <= '0;
      o_start_toggle <= 1'b0;
    end else if (take_start) begin
      o_frame.count  <= CNT_W'(1);
      o_frame.bits   <= '0;
      o_start_toggle <= ~o_start_toggle;  // [R8]
    end else if (started) begin
      o_frame.bits   <= {o_frame.bits[BITS_W-2:0], i_serial_in_pin};  // [R1] [R2]
      o_frame.count  <= at_max ? CNT_MAX : o_frame.count + CNT_W'(1);
    end
  end

endmodule

// *** src/sec_eeprom_cmd.sv ***
// Purpose: Command framing core of a three-wire serial EEPROM with program timer.
// Assumes: The host keeps select low for the least deselect time between frames.
// Notes:   Frames decode once select falls; reads are not driven on the data pin.
`timescale 1ns/10ps

// Summary of operation
// [R1] Serial input is sampled on shift clock rising edges only while select is high.
// [R2] Host sends start bit, opcode, address, then data, in that order.
// [R3] Select falling ends the frame being received.
// [R4] Host keeps select low at least 0.2 us between commands.
// [R5] With select low the device ignores shift clock and serial input.
// [R6] Every memory word starts as all ones.
// [R7] A program cycle ends well within 4.0 ms, then ready is reported.
// [R8] The first high input bit after select rises is the start bit.
// [R9] Program or erase begins when select falls after exactly the needed clocks.
// [R10] During programming, a raised select shows low for busy and high for ready.
// [R11] Program and erase run only while the write-unlock state is set.
// [R12] Serial output is released whenever select is low; the core releases it two core cycles after select falls.
module sec_eeprom_cmd
  import sec_pkg::*;
#(
  parameter int P_PROG_CYCLES = PROG_TYP_CYC
)
(
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  input  wire logic              i_shift_clock_pin,
  input  wire logic              i_select_pin,
  input  wire logic              i_serial_in_pin,
  input  wire logic [ADDR_W-1:0] i_mem_addr,
  output logic                   o_serial_out_pin,
  output logic                   o_serial_out_oe,
  output logic                   o_busy,
  output logic                   o_unlocked,
  output logic [DATA_W-1:0]      o_mem_data
);

  // Link side frame collection.
  sec_frame_s frame;
  logic       start_toggle;

  sec_frame_rx u_rx (
    .i_shift_clock_pin (i_shift_clock_pin),
    .i_reset_n         (i_reset_n),
    .i_select_pin      (i_select_pin),
    .i_serial_in_pin   (i_serial_in_pin),
    .o_frame           (frame),
    .o_start_toggle    (start_toggle)
  );

  // Two-stage synchronisers for select and the start toggle.
  logic sel_meta;
  logic sel_sync;
  logic sel_prev;
  logic tog_meta;
  logic tog_sync;
  logic tog_seen;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_meta <= 1'b0;
      sel_sync <= 1'b0;
      sel_prev <= 1'b0;
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
    end else begin
      sel_meta <= i_select_pin;
      sel_sync <= sel_meta;
      sel_prev <= sel_sync;
      tog_meta <= start_toggle;
      tog_sync <= tog_meta;
    end
  end

  // Frame end and whether the frame held a start bit at all.
  wire frame_end  = sel_prev & ~sel_sync;  // [R3]
  wire new_start  = (tog_sync != tog_seen);
  wire frame_ok   = frame_end & new_start;  // [R8]

  // The frame words are read only after select has been low for three core cycles.
  // The shift clock is stopped then, and the host's deselect time keeps them stable.
  wire              len_short = (frame.count == LEN_SHORT);
  wire              len_long  = (frame.count == LEN_LONG);
  wire [OPC_W-1:0]  s_opc     = frame.bits[S_OPC_LSB +: OPC_W];
  wire [OPC_W-1:0]  l_opc     = frame.bits[L_OPC_LSB +: OPC_W];
  wire [ADDR_W-1:0] s_addr    = frame.bits[0 +: ADDR_W];
  wire [ADDR_W-1:0] l_addr    = frame.bits[L_ADDR_LSB +: ADDR_W];
  wire [DATA_W-1:0] l_data    = frame.bits[0 +: DATA_W];
  wire [1:0]        s_sub     = s_addr[SUB_LSB +: 2];
  wire [1:0]        l_sub     = l_addr[SUB_LSB +: 2];

  // Command decode; any other clock count cancels the command.
  wire cmd_write  = len_long  & (l_opc == OPC_WRITE);  // [R9]
  wire cmd_wr_all = len_long  & (l_opc == OPC_EXT) & (l_sub == SUB_WR_ALL);  // [R9]
  wire cmd_erase  = len_short & (s_opc == OPC_ERASE);  // [R9]
  wire cmd_er_all = len_short & (s_opc == OPC_EXT) & (s_sub == SUB_ER_ALL);  // [R9]
  wire cmd_unlock = len_short & (s_opc == OPC_EXT) & (s_sub == SUB_UNLOCK);
  wire cmd_lock   = len_short & (s_opc == OPC_EXT) & (s_sub == SUB_LOCK);
  wire cmd_prog   = cmd_write | cmd_wr_all | cmd_erase | cmd_er_all;

  // Program request assembled from whichever form was received.
  sec_prog_s next_req;
  assign next_req.all  = cmd_wr_all | cmd_er_all;
  assign next_req.addr = len_long ? l_addr : s_addr;
  assign next_req.data = (cmd_erase | cmd_er_all) ? ERASED_WORD : l_data;

  // Controller state.
  sec_state_e         state;
  sec_prog_s          req;
  logic [TIMER_W-1:0] timer;
  logic               unlocked;
  logic               verify_arm;

  wire idle      = (state == ST_IDLE);
  wire accept    = frame_ok & idle;  // inputs during programming are ignored
  wire start_pgm = accept & cmd_prog & unlocked;  // [R11] [R9]
  wire timer_end = ~idle & (timer == '0);
  wire commit    = timer_end;

  // Consume the start toggle once a frame closes, busy or not.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tog_seen <= 1'b0;
    end else if (frame_end) begin
      tog_seen <= tog_sync;
    end
  end

  // Write-unlock state: set and cleared by its own commands, off after reset.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      unlocked <= UNLOCK_INIT;
    end else if (accept & cmd_unlock) begin
      unlocked <= 1'b1;  // [R11]
    end else if (accept & cmd_lock) begin
      unlocked <= 1'b0;  // [R11]
    end
  end

  // Program timer; the typical duration stays below the longest allowed.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ST_IDLE;
      timer <= '0;
      req   <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start_pgm) begin
            state <= ST_PROG;
            timer <= TIMER_W'(P_PROG_CYCLES - 1);  // [R7]
            req   <= next_req;
          end
        end
        ST_PROG: begin
          if (timer_end) begin
            state <= ST_IDLE;  // [R7]
          end else begin
            timer <= timer - TIMER_W'(1);
          end
        end
      endcase
    end
  end

  // Status drive arms after a program cycle starts and drops at the next start bit seen while idle.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      verify_arm <= 1'b0;
    end else if (start_pgm) begin
      verify_arm <= 1'b1;  // [R10]
    end else if (idle & new_start & sel_sync) begin
      verify_arm <= 1'b0;  // a new command releases the pin at once
    end
  end

  // Memory words, all ones from reset; whole-array commands write every entry.
  logic [DATA_W-1:0] mem [MEM_WORDS];

  for (genvar g = 0; g < MEM_WORDS; g++) begin : g_word
    wire hit = commit & (req.all | (req.addr == ADDR_W'(g)));
    always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        mem[g] <= MEM_INIT;  // [R6]
      end else if (hit) begin
        mem[g] <= req.data;
      end
    end
  end

  // Registered outputs: ready level, status and a backdoor word read.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_serial_out_pin <= 1'b0;
      o_busy           <= 1'b0;
      o_unlocked       <= UNLOCK_INIT;
      o_mem_data       <= MEM_INIT;
    end else begin
      // The last timer cycle already shows ready, so busy lasts exactly the program length.
      o_serial_out_pin <= (idle & ~start_pgm) | timer_end;  // [R10]
      o_busy           <= (~idle & ~timer_end) | start_pgm;  // [R7]
      o_unlocked       <= unlocked;
      o_mem_data       <= mem[i_mem_addr];
    end
  end

  // The pin is driven only with synchronised select high and, once idle, before a new start bit.
  assign o_serial_out_oe = sel_sync & verify_arm & ~(idle & new_start);  // [R12] [R10]

endmodule

// *** dv/sec_eeprom_cmd_chk.sv ***
// Purpose: Port assertions for the command frame core.
// Assumes: Host keeps select low at least 50 core cycles between frames.
// Notes:   Bound to every instance of the core below.
`timescale 1ns/10ps
module sec_eeprom_cmd_chk #(
  parameter int P_PROG_CYCLES = 50
)
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_select_pin,
  input wire logic o_serial_out_pin,
  input wire logic o_serial_out_oe,
  input wire logic o_busy,
  input wire logic o_unlocked
);
  int busy_len;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Counts busy cycles so a timer stuck or off by one shows at the fall.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) busy_len <= 0;
    else busy_len <= o_busy ? busy_len + 1 : 0;
  end
  property p_oe_off; !i_select_pin [*3] |-> !o_serial_out_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe high while deselected");
  property p_busy_len; $fell(o_busy) |-> busy_len == P_PROG_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("program length wrong");
  property p_busy_dout; o_busy |-> !o_serial_out_pin; endproperty
  a_busy_dout: assert property (p_busy_dout) else $error("output high while busy");
  property p_ready; $fell(o_busy) |-> ##[0:1] o_serial_out_pin; endproperty
  a_ready: assert property (p_ready) else $error("no ready after program");
  property p_start_sel; $rose(o_busy) |-> !i_select_pin && !$past(i_select_pin, 2); endproperty
  a_start_sel: assert property (p_start_sel) else $error("program began while selected");
  property p_lock; $rose(o_busy) |-> $past(o_unlocked); endproperty
  a_lock: assert property (p_lock) else $error("program while locked");
  property p_unlock_sel; $changed(o_unlocked) |-> !i_select_pin; endproperty
  a_unlock_sel: assert property (p_unlock_sel) else $error("unlock changed mid frame");
  property p_oe_busy; i_select_pin [*3] ##0 o_busy |-> o_serial_out_oe; endproperty
  a_oe_busy: assert property (p_oe_busy) else $error("status not driven");
endmodule
bind sec_eeprom_cmd sec_eeprom_cmd_chk #(.P_PROG_CYCLES(P_PROG_CYCLES)) i_chk (
  .i_clk(i_clk),
  .i_reset_n(i_reset_n),
  .i_select_pin(i_select_pin),
  .o_serial_out_pin(o_serial_out_pin),
  .o_serial_out_oe(o_serial_out_oe),
  .o_busy(o_busy),
  .o_unlocked(o_unlocked)
);

// *** dv/sec_host_model.sv ***
// Purpose: Host model driving select, shift clock and serial input.
// Assumes: Shift clock period 32 ns, still outside frames except when a send with en low clocks bits with select low.
// Notes:   Data input flips after each frame so no stale level lingers.
`timescale 1ns/10ps
module sec_host_model
(
  output logic o_select_pin,
  output logic o_shift_clock_pin,
  output logic o_serial_in_pin
);
  // Idle bus: deselected, clock still.
  initial begin
    o_select_pin = 1'b0;
    o_shift_clock_pin = 1'b0;
    o_serial_in_pin = 1'b0;
  end
  // Shifts n bits first bit first; en low clocks them with select held low.
  task automatic send(input logic [31:0] bits, input int n, input logic en);
    o_select_pin = en;
    #17.3;
    for (int k = n - 1; k >= 0; k--) begin
      o_serial_in_pin = bits[k];
      #16;
      o_shift_clock_pin = 1'b1;
      #16;
      o_shift_clock_pin = 1'b0;
    end
    o_serial_in_pin = ~o_serial_in_pin;
    o_select_pin = 1'b0;
    #208;
  endtask
  // Raises select for a status check; data input low so no start bit is seen.
  task automatic poll();
    o_serial_in_pin = 1'b0;
    o_select_pin = 1'b1;
  endtask
endmodule

// *** dv/tb.sv ***
// Purpose: Self-checking bench for the command frame core.
// Assumes: Program cycle shortened to P_PROG core cycles.
// Notes:   Table rows run back to back; status polling and then reset follow.
`timescale 1ns/10ps
module tb
  import sec_pkg::*;
;
  localparam int P_PROG = 100;
  typedef struct {
    logic [31:0] bits;
    int          n;
    logic        en;
    logic [9:0]  a;
    logic [15:0] d;
    logic        ul;
  } sec_row_s;
  logic        i_clk;
  logic        i_reset_n;
  logic [9:0]  i_mem_addr;
  logic        sel;
  logic        sck;
  logic        sdi;
  logic        sdo;
  logic        oe;
  logic        busy;
  logic        ul;
  logic [15:0] mdata;
  int          bad_count;
  int          cmp_count;
  // Frame, clock count, select, word to read back, its value, unlock state.
  sec_row_s rows[12] = '{
    '{{1'b1, OPC_WRITE, 10'h005, 16'h1234}, 29, 1'b1, 10'h005, 16'hffff, 1'b0},
    '{{1'b1, OPC_EXT, SUB_UNLOCK, 8'h00}, 13, 1'b0, 10'h005, 16'hffff, 1'b0},
    '{{1'b1, OPC_EXT, SUB_UNLOCK, 8'h00}, 16, 1'b1, 10'h005, 16'hffff, 1'b1},
    '{{1'b1, OPC_WRITE, 10'h005, 16'ha5c3}, 29, 1'b1, 10'h005, 16'ha5c3, 1'b1},
    '{{1'b1, OPC_WRITE, 10'h3ff, 16'h0001, 1'b0}, 30, 1'b1, 10'h3ff, 16'hffff, 1'b1},
    '{{1'b1, OPC_WRITE, 10'h3ff, 15'h0000}, 28, 1'b1, 10'h3ff, 16'hffff, 1'b1},
    '{{1'b1, OPC_ERASE, 10'h005}, 13, 1'b1, 10'h005, 16'hffff, 1'b1},
    '{{1'b1, OPC_EXT, SUB_WR_ALL, 8'h00, 16'h5a5a}, 29, 1'b1, 10'h200, 16'h5a5a, 1'b1},
    '{{1'b1, OPC_READ, 10'h200}, 13, 1'b1, 10'h200, 16'h5a5a, 1'b1},
    '{{1'b1, OPC_EXT, SUB_ER_ALL, 8'h00}, 13, 1'b1, 10'h200, 16'hffff, 1'b1},
    '{{1'b1, OPC_EXT, SUB_LOCK, 8'h00}, 13, 1'b1, 10'h200, 16'hffff, 1'b0},
    '{{1'b1, OPC_WRITE, 10'h200, 16'h0000}, 29, 1'b1, 10'h200, 16'hffff, 1'b0}
  };
  sec_host_model i_host (
    .o_select_pin(sel),
    .o_shift_clock_pin(sck),
    .o_serial_in_pin(sdi)
  );
  sec_eeprom_cmd #(.P_PROG_CYCLES(P_PROG)) i_dut (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_shift_clock_pin(sck),
    .i_select_pin(sel),
    .i_serial_in_pin(sdi),
    .i_mem_addr(i_mem_addr),
    .o_serial_out_pin(sdo),
    .o_serial_out_oe(oe),
    .o_busy(busy),
    .o_unlocked(ul),
    .o_mem_data(mdata)
  );
  // Core clock, 4 ns period.
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Samples one step after the edge so the edge's updates have landed.
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 400 && busy !== 1'b0; k++) cyc(1);
    if (k == 400) begin
      bad_count++;
      complete_run();
    end
  endtask
  // A hang past this point is a failure.
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
  initial begin
    i_reset_n = 1'b0;
    i_mem_addr = 10'h000;
    bad_count = 0;
    cmp_count = 0;
    cyc(3);
    chk("busy", 16'h0000, busy);
    chk("oe", 16'h0000, oe);
    chk("unlocked", 16'h0000, ul);
    chk("mem", 16'hffff, mdata);
    @(posedge i_clk) i_reset_n <= 1'b1;
    foreach (rows[i]) begin
      i_host.send(rows[i].bits, rows[i].n, rows[i].en);
      wait_idle();
      @(posedge i_clk) i_mem_addr <= rows[i].a;
      cyc(2);
      chk("mem", rows[i].d, mdata);
      chk("unlocked", rows[i].ul, ul);
    end
    // Status polling while a write is still in progress.
    i_host.send({1'b1, OPC_EXT, SUB_UNLOCK, 8'h00}, 13, 1'b1);
    i_host.send({1'b1, OPC_WRITE, 10'h010, 16'hbeef}, 29, 1'b1);
    i_host.poll();
    cyc(4);
    chk("busy", 16'h0001, busy);
    chk("oe", 16'h0001, oe);
    chk("out", 16'h0000, sdo);
    wait_idle();
    cyc(1);
    chk("out", 16'h0001, sdo);
    chk("oe", 16'h0001, oe);
    i_host.send(32'h0, 0, 1'b0);
    chk("oe", 16'h0000, oe);
    @(posedge i_clk) i_mem_addr <= 10'h010;
    cyc(2);
    chk("mem", 16'hbeef, mdata);
    // Reset in mid-run clears the unlock state and refills the memory with ones.
    @(posedge i_clk) i_reset_n <= 1'b0;
    cyc(2);
    chk("unlocked", 16'h0000, ul);
    chk("mem", 16'hffff, mdata);
    @(posedge i_clk) i_reset_n <= 1'b1;
    cyc(2);
    chk("busy", 16'h0000, busy);
    chk("mem", 16'hffff, mdata);
    complete_run();
  end
endmodule
